// ===== rtl/pss_top.sv
// Priority shadow set select logic with register port
// Summary of operation
// R1: Bits 15-12 pick level 3 set
// R2: Bits 11-8 pick level 2 set
// R3: Bits 7-4 pick level 1 set
// R4: Reserved top-bit codes map to set 0
// R5: Bit 0 gives single vector a set
// R6: Fields ignored when multi-vector mode off
// R7: Bits 3-1 read as zero
// R8: Set number forwarded with vector to core
`timescale 1ns/1ps
module pss_top (
   input  wire logic                         clk_in,
   input  wire logic                         arst_n_in,
   input  wire logic [pss_pkg::ADDR_W-1:0]   addr_in,
   input  wire logic [pss_pkg::DATA_W-1:0]   wdata_in,
   input  wire logic                         wr_in,
   input  wire logic                         rd_in,
   output logic      [pss_pkg::DATA_W-1:0]   rdata_out,
   input  wire pss_pkg::pss_req_t            req_in,
   output pss_pkg::pss_entry_t               entry_out
);
   logic                         rst_meta_ff;
   logic                         rst_sync_ff;
   logic                         rst_n;
   logic [pss_pkg::FIELD_W-1:0]  l3_field_ff;
   logic [pss_pkg::FIELD_W-1:0]  l2_field_ff;
   logic [pss_pkg::FIELD_W-1:0]  l1_field_ff;
   logic                         sv_en_ff;
   logic                         mv_mode_ff;
   logic [pss_pkg::FIELD_W-1:0]  nxt_l3_field;
   logic [pss_pkg::FIELD_W-1:0]  nxt_l2_field;
   logic [pss_pkg::FIELD_W-1:0]  nxt_l1_field;
   logic                         nxt_sv_en;
   logic                         nxt_mv_mode;
   logic                         sel_wr;
   logic                         ctl_wr;
   logic [pss_pkg::DATA_W-1:0]   rdata_ff;
   logic [pss_pkg::DATA_W-1:0]   nxt_rdata;
   pss_pkg::pss_entry_t          entry_ff;
   pss_pkg::pss_entry_t          nxt_entry;
   logic [pss_pkg::PRI_W-1:0]    last_pri_ff;
   logic [pss_pkg::PRI_W-1:0]    nxt_last_pri;
   logic [pss_pkg::SET_W-1:0]    set_l3;
   logic [pss_pkg::SET_W-1:0]    set_l2;
   logic [pss_pkg::SET_W-1:0]    set_l1;
   logic [pss_pkg::DATA_W-1:0]   select_word;
   logic [pss_pkg::DATA_W-1:0]   status_word;
   logic [pss_pkg::SET_W-1:0]    pick_set;
   logic                         pick_use;

   // Reset release synchroniser
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   // Internal reset for all other state
   assign rst_n = rst_sync_ff;

   // Field decoders, reserved codes give set 0
   pss_field_decode u_dec_l3 (
      .field_in (l3_field_ff),
      .set_out  (set_l3)
   );
   pss_field_decode u_dec_l2 (
      .field_in (l2_field_ff),
      .set_out  (set_l2)
   );
   pss_field_decode u_dec_l1 (
      .field_in (l1_field_ff),
      .set_out  (set_l1)
   );

   // Write decode
   assign sel_wr = wr_in && (addr_in == pss_pkg::ADDR_SELECT);
   assign ctl_wr = wr_in && (addr_in == pss_pkg::ADDR_CONTROL);

   // Shadow select register writes
   always_comb begin
      nxt_l3_field = l3_field_ff;
      nxt_l2_field = l2_field_ff;
      nxt_l1_field = l1_field_ff;
      nxt_sv_en    = sv_en_ff;
      if (sel_wr) begin
         nxt_l3_field = wdata_in[pss_pkg::L3_LSB +: pss_pkg::FIELD_W]; // R1
         nxt_l2_field = wdata_in[pss_pkg::L2_LSB +: pss_pkg::FIELD_W]; // R2
         nxt_l1_field = wdata_in[pss_pkg::L1_LSB +: pss_pkg::FIELD_W]; // R3
         nxt_sv_en    = wdata_in[pss_pkg::SV_BIT];                     // R5
      end
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         l3_field_ff <= pss_pkg::SELECT_RESET[pss_pkg::L3_LSB +: pss_pkg::FIELD_W];
         l2_field_ff <= pss_pkg::SELECT_RESET[pss_pkg::L2_LSB +: pss_pkg::FIELD_W];
         l1_field_ff <= pss_pkg::SELECT_RESET[pss_pkg::L1_LSB +: pss_pkg::FIELD_W];
         sv_en_ff    <= pss_pkg::SELECT_RESET[pss_pkg::SV_BIT];
      end else begin
         l3_field_ff <= nxt_l3_field;
         l2_field_ff <= nxt_l2_field;
         l1_field_ff <= nxt_l1_field;
         sv_en_ff    <= nxt_sv_en;
      end
   end

   // Control register writes
   always_comb begin
      nxt_mv_mode = mv_mode_ff;
      if (ctl_wr) begin
         nxt_mv_mode = wdata_in[pss_pkg::MV_MODE_BIT];
      end
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         mv_mode_ff <= pss_pkg::MV_MODE_RESET;
      end else begin
         mv_mode_ff <= nxt_mv_mode;
      end
   end

   // Shadow select word as software sees it
   always_comb begin
      select_word = '0;
      select_word[pss_pkg::L3_LSB +: pss_pkg::FIELD_W] = l3_field_ff;
      select_word[pss_pkg::L2_LSB +: pss_pkg::FIELD_W] = l2_field_ff;
      select_word[pss_pkg::L1_LSB +: pss_pkg::FIELD_W] = l1_field_ff;
      select_word[pss_pkg::RESV_BIT:pss_pkg::SV_BIT+1] = '0; // R7
      select_word[pss_pkg::SV_BIT] = sv_en_ff;
   end

   // Status word: last entry handed to the core
   always_comb begin
      status_word = '0;
      status_word[pss_pkg::ST_SET_LSB +: pss_pkg::SET_W] = entry_ff.set_num;
      status_word[pss_pkg::ST_USE_BIT] = entry_ff.use_set;
      status_word[pss_pkg::ST_PRI_LSB +: pss_pkg::PRI_W] = last_pri_ff;
   end

   // Read data, one cycle after the strobe
   always_comb begin
      nxt_rdata = '0;
      if (rd_in) begin
         case (addr_in)
            pss_pkg::ADDR_SELECT: begin
               nxt_rdata = select_word;
            end
            pss_pkg::ADDR_CONTROL: begin
               nxt_rdata[pss_pkg::MV_MODE_BIT] = mv_mode_ff;
            end
            pss_pkg::ADDR_STATUS: begin
               nxt_rdata = status_word;
            end
            default: begin
               nxt_rdata = '0;
            end
         endcase
      end
   end

   // Set choice for the requesting priority
   always_comb begin
      pick_set = pss_pkg::SET_ZERO;
      pick_use = sv_en_ff; // R5
      if (mv_mode_ff) begin // R6
         pick_use = 1'b1;
         case (req_in.priority_level)
            pss_pkg::PRI_THREE: begin
               pick_set = set_l3; // R1
            end
            pss_pkg::PRI_TWO: begin
               pick_set = set_l2; // R2
            end
            pss_pkg::PRI_ONE: begin
               pick_set = set_l1; // R3
            end
            default: begin
               pick_set = pss_pkg::SET_ZERO;
            end
         endcase
      end
   end

   // Interrupt entry: set choice beside the vector
   always_comb begin
      nxt_entry       = entry_ff;
      nxt_last_pri    = last_pri_ff;
      nxt_entry.valid = req_in.valid;
      if (req_in.valid) begin
         nxt_entry.vector  = req_in.vector; // R8
         nxt_entry.use_set = pick_use;
         nxt_entry.set_num = pick_set; // R8
         nxt_last_pri      = req_in.priority_level;
      end
   end

   // Entry register toward the core
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         entry_ff    <= '0;
         last_pri_ff <= '0;
      end else begin
         entry_ff    <= nxt_entry; // R8
         last_pri_ff <= nxt_last_pri;
      end
   end

   // Read data register
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata_out = rdata_ff;
   assign entry_out = entry_ff;
endmodule : pss_top

// ===== inc/pss_pkg.sv
// Package for the priority shadow set select block
package pss_pkg;
   localparam int         DATA_W        = 32;
   localparam int         ADDR_W        = 8;
   localparam int         SET_W         = 3;
   localparam int         FIELD_W       = 4;
   localparam int         PRI_W         = 3;
   localparam int         VEC_W         = 6;

   // Register byte addresses
   localparam logic [7:0] ADDR_SELECT   = 8'h00;
   localparam logic [7:0] ADDR_CONTROL  = 8'h04;
   localparam logic [7:0] ADDR_STATUS   = 8'h08;

   // Field positions in the shadow select register
   localparam int         L3_LSB        = 12;
   localparam int         L2_LSB        = 8;
   localparam int         L1_LSB        = 4;
   localparam int         SV_BIT        = 0;
   localparam int         RESV_BIT      = 3;

   // Control register: multi-vector mode bit
   localparam int         MV_MODE_BIT   = 12;

   // Status register layout
   localparam int         ST_SET_LSB    = 0;
   localparam int         ST_USE_BIT    = 4;
   localparam int         ST_PRI_LSB    = 8;

   localparam logic [15:0] SELECT_RESET  = 16'h0000;
   localparam logic        MV_MODE_RESET = 1'b0;
   localparam logic [2:0]  SET_ZERO      = 3'h0;
   localparam logic [2:0]  PRI_ONE       = 3'h1;
   localparam logic [2:0]  PRI_TWO       = 3'h2;
   localparam logic [2:0]  PRI_THREE     = 3'h3;

   typedef struct packed {
      logic             valid;
      logic [PRI_W-1:0] priority_level;
      logic [VEC_W-1:0] vector;
   } pss_req_t;

   typedef struct packed {
      logic             valid;
      logic [VEC_W-1:0] vector;
      logic             use_set;
      logic [SET_W-1:0] set_num;
   } pss_entry_t;
endpackage : pss_pkg

// ===== rtl/pss_field_decode.sv
// Decoder of one per-priority shadow set field
`timescale 1ns/1ps
module pss_field_decode (
   input  wire logic [pss_pkg::FIELD_W-1:0] field_in,
   output logic      [pss_pkg::SET_W-1:0]   set_out
);
   always_comb begin
      if (field_in[pss_pkg::FIELD_W-1]) begin
         set_out = pss_pkg::SET_ZERO; // R4
      end else begin
         set_out = field_in[pss_pkg::SET_W-1:0];
      end
   end
endmodule : pss_field_decode

// ===== tb/pss_core_model.sv
// Core side model latching each entry
`timescale 1ns/1ps
module pss_core_model (
   input  wire logic                clk_in,
   input  wire logic                arst_n_in,
   input  wire pss_pkg::pss_entry_t entry_in,
   output pss_pkg::pss_entry_t      seen_out
);
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         seen_out <= '0;
      end else if (entry_in.valid) begin
         seen_out <= entry_in;
      end
   end
endmodule : pss_core_model

// ===== tb/pss_props.sv
// Checker for the shadow set select block
`timescale 1ns/1ps
module pss_props (
   input wire logic                clk_in,
   input wire logic                arst_n_in,
   input wire logic [7:0]          addr_in,
   input wire logic [31:0]         wdata_in,
   input wire logic                wr_in,
   input wire logic                rd_in,
   input wire logic [31:0]         rdata_out,
   input wire pss_pkg::pss_req_t   req_in,
   input wire pss_pkg::pss_entry_t entry_out
);
   logic [15:0] sel_ff;
   logic        mv_ff;
   logic [2:0]  exp_l3;
   logic [2:0]  exp_l2;
   logic [2:0]  exp_l1;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   function automatic logic [2:0] dec(input logic [3:0] f);
      return f[3] ? 3'h0 : f[2:0];
   endfunction : dec
   assign exp_l3 = dec(sel_ff[15:12]);
   assign exp_l2 = dec(sel_ff[11:8]);
   assign exp_l1 = dec(sel_ff[7:4]);
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sel_ff <= 16'h0000;
         mv_ff  <= 1'b0;
      end else if (wr_in && addr_in == 8'h00) begin
         sel_ff <= wdata_in[15:0];
      end else if (wr_in && addr_in == 8'h04) begin
         mv_ff <= wdata_in[12];
      end
   end
   property p_val; req_in.valid |=> entry_out.valid; endproperty
   a_val: assert property (p_val) else $error("entry missing");
   property p_idle; !req_in.valid |=> !entry_out.valid; endproperty
   a_idle: assert property (p_idle) else $error("stray entry");
   property p_vec; req_in.valid |=> entry_out.vector == $past(req_in.vector); endproperty
   a_vec: assert property (p_vec) else $error("vector wrong");
   property p_l3;
      req_in.valid && mv_ff && req_in.priority_level == 3'h3 |=> entry_out.set_num == $past(exp_l3);
   endproperty
   a_l3: assert property (p_l3) else $error("level 3 set wrong");
   property p_l2;
      req_in.valid && mv_ff && req_in.priority_level == 3'h2 |=> entry_out.set_num == $past(exp_l2);
   endproperty
   a_l2: assert property (p_l2) else $error("level 2 set wrong");
   property p_l1;
      req_in.valid && mv_ff && req_in.priority_level == 3'h1 |=> entry_out.set_num == $past(exp_l1);
   endproperty
   a_l1: assert property (p_l1) else $error("level 1 set wrong");
   property p_sv;
      req_in.valid && !mv_ff |=> entry_out.set_num == 3'h0 && entry_out.use_set == $past(sel_ff[0]);
   endproperty
   a_sv: assert property (p_sv) else $error("single vector set wrong");
   property p_mvu; req_in.valid && mv_ff |=> entry_out.use_set; endproperty
   a_mvu: assert property (p_mvu) else $error("multi vector entry without set");
   property p_ro; rd_in && addr_in == 8'h00 |=> rdata_out[3:1] == 3'h0; endproperty
   a_ro: assert property (p_ro) else $error("bits 3-1 not zero");
endmodule : pss_props
bind pss_top pss_props pss_props_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .req_in(req_in), .entry_out(entry_out));

// ===== tb/pss_top_bench.sv
// Bench for the shadow set select block
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
   $display("[FAIL] %0t value mismatch", $time); end end
module pss_top_bench;
   logic                clk_in    = 1'b0;
   logic                arst_n_in = 1'b0;
   logic [7:0]          addr_in   = 8'h00;
   logic [31:0]         wdata_in  = 32'h0;
   logic                wr_in     = 1'b0;
   logic                rd_in     = 1'b0;
   logic [31:0]         rdata_out;
   pss_pkg::pss_req_t   req_in    = '0;
   pss_pkg::pss_entry_t entry_out;
   pss_pkg::pss_entry_t seen;
   int                  err_total = 0;
   int                  samples_checked = 0;
   always #2 clk_in = ~clk_in;
   pss_top pss_top_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .req_in(req_in), .entry_out(entry_out));
   pss_core_model pss_core_model_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .entry_in(entry_out),
      .seen_out(seen));
   task automatic wrap_up();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 `CHK(rdata_out, e)
   endtask : rd
   task automatic ent(input logic [2:0] p, input logic u, input logic [2:0] s);
      int i;
      @(posedge clk_in);
      req_in <= '{1'b1, p, {3'h5, p}};
      @(posedge clk_in);
      req_in.valid <= 1'b0;
      #1;
      for (i = 0; i < 4 && entry_out.valid !== 1'b1; i++) begin
         @(posedge clk_in);
         #1;
      end
      if (i < 4) begin
         @(posedge clk_in);
         #1 `CHK({seen.vector, seen.use_set, seen.set_num}, {3'h5, p, u, s})
      end else begin
         err_total++;
         $display("[FAIL] %0t entry timeout", $time);
         wrap_up();
      end
   endtask : ent
   function automatic logic [2:0] dec(input logic [3:0] f);
      return f[3] ? 3'h0 : f[2:0];
   endfunction : dec
   initial begin
      logic [3:0] c;
      repeat (16) @(posedge clk_in);
      arst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      wr(8'h10, 32'hffff_ffff);
      rd(8'h10, 32'h0);
      wr(8'h00, 32'hffff_ffff);
      rd(8'h00, 32'h0000_fff1);
      $display("register test done");
      ent(3'h3, 1'b1, 3'h0);
      wr(8'h00, 32'h0000_7770);
      ent(3'h2, 1'b0, 3'h0);
      $display("single vector test done");
      wr(8'h04, 32'h0000_1000);
      rd(8'h04, 32'h0000_1000);
      for (int k = 0; k < 16; k++) begin
         c = 4'(k);
         wr(8'h00, {16'h0, c, c + 4'h1, c + 4'h2, 4'h0});
         ent(3'h3, 1'b1, dec(c));
         ent(3'h2, 1'b1, dec(c + 4'h1));
         ent(3'h1, 1'b1, dec(c + 4'h2));
      end
      rd(8'h08, 32'h0000_0111);
      ent(3'h0, 1'b1, 3'h0);
      $display("multi vector test done");
      wrap_up();
   end
endmodule : pss_top_bench
